// ==== hw/fde_pkg.sv ====
package fde_pkg;
// Behaviour
// - output equals weighted sum over weight sum
// - numerator adds singleton times its rule weight
// - triangles: vertex, left and right semi-base
// - activation height limited to four bits
// - three shape bytes fetched below one kilobyte
// - program order, grouping through buffer register
// - four-antecedent rule takes about three microseconds
// - load alpha pushes activation onto stack
// - load complement pushes complemented activation
// - fuzzy min combines two latest operands
// - fuzzy max combines two latest operands
// - keep result pushes last result back
// - save copies result register into buffer
// - restore pushes buffer onto operand stack
// - consequent accumulates product and weight
// - defuzzify-store divides and writes result byte
// - start instruction hands execution to engine
// - control returns after final byte written
// - eight byte input registers loaded beforehand
// - min for and, max for or

	// the rule time holds at a 50 ns clock; as a cycle count the
	// budget still applies when the system clock runs slower
	localparam int RULE_CLK_NS  = 50;
	localparam int RULE_TIME_NS = 3000;
	localparam int RULE_CYCLES  = RULE_TIME_NS / RULE_CLK_NS;

	localparam int NUM_INPUTS = 8;
	localparam int STK_DEPTH  = 4;

	// instruction word fields
	localparam int OP_MSB   = 15;
	localparam int OP_LSB   = 12;
	localparam int LAST_BIT = 11;
	localparam int SEL_MSB  = 10;
	localparam int SEL_LSB  = 8;
	localparam int ARG_MSB  = 7;
	localparam int ADDR_MSB = 6;

	localparam logic [3:0] ALPHA_MAX    = 4'hF;
	// a height never exceeds 15, so four quotient bits are enough
	localparam logic [4:0] ALPHA_STEPS  = 5'h04;
	localparam logic [4:0] DEFUZZ_STEPS = 5'h18;
	localparam logic [2:0] STK_FULL     = 3'h4;
	localparam logic [1:0] MBF_LAST     = 2'h3;

	typedef logic [3:0]  fde_alpha_t;
	typedef logic [11:0] fde_paddr_t;
	typedef logic [9:0]  fde_maddr_t;

	typedef enum logic [3:0] {
		OP_NOP        = 4'h0,
		OP_LOAD_ALPHA = 4'h1,
		OP_LOAD_COMPL = 4'h2,
		OP_MIN        = 4'h3,
		OP_MAX        = 4'h4,
		OP_KEEP       = 4'h5,
		OP_SAVE       = 4'h6,
		OP_RESTORE    = 4'h7,
		OP_CONSEQ     = 4'h8,
		OP_OUT        = 4'h9
	} fde_op_e;

	typedef enum logic [2:0] {
		S_IDLE   = 3'h0,
		S_FETCH  = 3'h1,
		S_DECODE = 3'h2,
		S_MBF    = 3'h3,
		S_ALPHA  = 3'h4,
		S_DIV    = 3'h5
	} fde_state_e;

	typedef struct packed {
		logic       we;
		logic [2:0] sel;
		logic [7:0] data;
	} fde_load_s;

	typedef struct packed {
		logic       we;
		logic [6:0] addr;
		logic [7:0] data;
	} fde_res_s;

	typedef struct packed {
		logic [STK_DEPTH-1:0][3:0] val;
		logic [2:0]                sp;
	} fde_stack_s;

	typedef struct packed {
		fde_state_e                 st;
		fde_paddr_t                 pc;
		logic [15:0]                ir;
		fde_stack_s                 stk;
		fde_alpha_t                 k;
		fde_alpha_t                 m;
		logic [NUM_INPUTS-1:0][7:0] inreg;
		logic [2:0][7:0]            mb;
		logic [1:0]                 cnt;
		fde_maddr_t                 mbf_addr;
		logic [23:0]                num;
		logic [11:0]                den;
		logic [23:0]                dq;
		logic [16:0]                dr;
		logic [15:0]                dd;
		logic [4:0]                 dn;
		logic                       dmode;
		logic                       busy;
		logic                       done;
		fde_res_s                   res;
	} fde_state_s;

	localparam fde_state_s STATE_RST = '0;
endpackage

// ==== hw/fde_engine.sv ====
`timescale 1ns/1ns
module fde_engine (
	input  wire logic               clk_in,
	input  wire logic               rst_in,
	input  wire logic               start_in,
	input  wire fde_pkg::fde_paddr_t start_addr_in,
	input  wire fde_pkg::fde_load_s  load_in,
	input  wire logic [15:0]        instr_in,
	input  wire logic [7:0]         mbf_data_in,
	output fde_pkg::fde_paddr_t     prog_addr_out,
	output fde_pkg::fde_maddr_t     mbf_addr_out,
	output fde_pkg::fde_res_s       res_out,
	output logic                    busy_out,
	output logic                    done_out
);
	import fde_pkg::*;

	fde_state_s r_reg;
	fde_state_s r_next;

	fde_op_e    op_w;
	logic [2:0] t_i;
	logic [2:0] n_i;
	fde_alpha_t top_w;
	fde_alpha_t nxt_w;
	logic [7:0] x_w;
	logic [7:0] v_w;
	logic       cmp_w;
	logic [7:0] mbf_idx_w;

	function automatic fde_stack_s push(fde_stack_s s, fde_alpha_t v);
		fde_stack_s o;
		o = s;
		// a full stack drops its oldest entry rather than the newest
		if (s.sp == STK_FULL) begin
			o.val[STK_DEPTH-2:0] = s.val[STK_DEPTH-1:1];
			o.val[STK_DEPTH-1] = v;
		end else begin
			o.val[s.sp[1:0]] = v;
			o.sp = s.sp + 3'h1;
		end
		return o;
	endfunction

	function automatic fde_alpha_t alpha_sel(fde_alpha_t a, logic c);
		return c ? ALPHA_MAX - a : a;
	endfunction

	function automatic fde_state_s finish_out(fde_state_s s,
			logic [7:0] v, logic last);
		fde_state_s o;
		o = s;
		o.res.we = 1'b1;
		o.res.data = v;
		o.num = '0;
		o.den = '0;
		if (last) begin
			o.done = 1'b1;
			o.busy = 1'b0;
			o.st = S_IDLE;
		end else begin
			o.st = S_FETCH;
		end
		return o;
	endfunction

	assign op_w      = fde_op_e'(instr_in[OP_MSB:OP_LSB]);
	assign t_i       = r_reg.stk.sp - 3'h1;
	assign n_i       = r_reg.stk.sp - 3'h2;
	assign top_w     = (r_reg.stk.sp >= 3'h1) ? r_reg.stk.val[t_i[1:0]] : '0;
	assign nxt_w     = (r_reg.stk.sp >= 3'h2) ? r_reg.stk.val[n_i[1:0]] : '0;
	assign x_w       = r_reg.inreg[r_reg.ir[SEL_MSB:SEL_LSB]];
	assign v_w       = r_reg.mb[1];
	assign cmp_w     = r_reg.ir[OP_MSB:OP_LSB] == OP_LOAD_COMPL;
	assign mbf_idx_w = instr_in[ARG_MSB:0];

	always_comb begin
		logic [7:0]  base;
		logic [7:0]  d;
		logic [7:0]  span;
		logic [11:0] dvd;
		logic [16:0] rem;
		logic        q;
		fde_alpha_t  a;
		base = '0;
		d = '0;
		span = '0;
		dvd = '0;
		rem = '0;
		q = 1'b0;
		a = '0;
		r_next = r_reg;
		r_next.res.we = 1'b0;
		r_next.done = 1'b0;
		if (load_in.we) begin
			r_next.inreg[load_in.sel] = load_in.data;
		end
		case (r_reg.st)
			S_IDLE: begin
				if (start_in) begin
					r_next.pc = start_addr_in;
					r_next.busy = 1'b1;
					r_next.stk = '0;
					r_next.k = '0;
					r_next.m = '0;
					r_next.num = '0;
					r_next.den = '0;
					r_next.st = S_FETCH;
				end
			end
			S_FETCH: begin
				r_next.st = S_DECODE;
			end
			S_DECODE: begin
				// program order: each instruction finishes before the next
				r_next.ir = instr_in;
				r_next.pc = r_reg.pc + 12'h001;
				r_next.st = S_FETCH;
				case (op_w)
					OP_LOAD_ALPHA, OP_LOAD_COMPL: begin
						// three bytes per shape, index times three
						r_next.mbf_addr = {2'b00, mbf_idx_w}
							+ {1'b0, mbf_idx_w, 1'b0};
						r_next.cnt = '0;
						r_next.st = S_MBF;
					end
					OP_MIN: begin
						r_next.k = (top_w < nxt_w) ? top_w : nxt_w;
						r_next.stk.sp = (r_reg.stk.sp >= 3'h2)
							? r_reg.stk.sp - 3'h2 : 3'h0;
					end
					OP_MAX: begin
						r_next.k = (top_w > nxt_w) ? top_w : nxt_w;
						r_next.stk.sp = (r_reg.stk.sp >= 3'h2)
							? r_reg.stk.sp - 3'h2 : 3'h0;
					end
					OP_KEEP: begin
						r_next.stk = push(r_reg.stk, r_reg.k);
					end
					OP_SAVE: begin
						r_next.m = r_reg.k;
					end
					OP_RESTORE: begin
						r_next.stk = push(r_reg.stk, r_reg.m);
					end
					OP_CONSEQ: begin
						// widen first: an 8-bit product would wrap
						r_next.num = r_reg.num + {12'h000,
							{4'h0, instr_in[ARG_MSB:0]}
							* {8'h00, r_reg.k}};
						r_next.den = r_reg.den + {8'h00, r_reg.k};
					end
					OP_OUT: begin
						r_next.res.addr = instr_in[ADDR_MSB:0];
						if (r_reg.den == '0) begin
							r_next = finish_out(r_next, 8'h00,
								instr_in[LAST_BIT]);
						end else begin
							r_next.dq = r_reg.num;
							r_next.dr = '0;
							r_next.dd = {4'h0, r_reg.den};
							r_next.dn = DEFUZZ_STEPS;
							r_next.dmode = 1'b1;
							r_next.st = S_DIV;
						end
					end
					default: begin
					end
				endcase
			end
			S_MBF: begin
				// memory answers one cycle after the address stands
				if (r_reg.cnt != 2'h0) begin
					r_next.mb[r_reg.cnt - 2'h1] = mbf_data_in;
				end
				r_next.mbf_addr = r_reg.mbf_addr + 10'h001;
				r_next.cnt = r_reg.cnt + 2'h1;
				if (r_reg.cnt == MBF_LAST) begin
					r_next.st = S_ALPHA;
				end
			end
			S_ALPHA: begin
				if (x_w < v_w) begin
					d = v_w - x_w;
					base = r_reg.mb[0];
				end else begin
					d = x_w - v_w;
					base = r_reg.mb[2];
				end
				r_next.st = S_FETCH;
				if (x_w == v_w) begin
					a = alpha_sel(ALPHA_MAX, cmp_w);
					r_next.stk = push(r_reg.stk, a);
					r_next.k = a;
				end else if (d >= base) begin
					a = alpha_sel('0, cmp_w);
					r_next.stk = push(r_reg.stk, a);
					r_next.k = a;
				end else begin
					// height scales (base - d) * 15 / base, never above 15
					span = base - d;
					dvd = {span, 4'h0} - {4'h0, span};
					// dvd < 16 * base, so its top byte is already below
					// the divisor and only four quotient bits remain
					r_next.dq = {dvd[3:0], 20'h00000};
					r_next.dr = {9'h000, dvd[11:4]};
					r_next.dd = {8'h00, base};
					r_next.dn = ALPHA_STEPS;
					r_next.dmode = 1'b0;
					r_next.st = S_DIV;
				end
			end
			S_DIV: begin
				// one quotient bit per cycle keeps the divider small
				rem = {r_reg.dr[15:0], r_reg.dq[23]};
				if (rem >= {1'b0, r_reg.dd}) begin
					rem = rem - {1'b0, r_reg.dd};
					q = 1'b1;
				end
				r_next.dr = rem;
				r_next.dq = {r_reg.dq[22:0], q};
				r_next.dn = r_reg.dn - 5'h01;
				if (r_reg.dn == 5'h01) begin
					if (r_reg.dmode) begin
						r_next = finish_out(r_next, r_next.dq[7:0],
							r_reg.ir[LAST_BIT]);
					end else begin
						a = alpha_sel(r_next.dq[3:0], cmp_w);
						r_next.stk = push(r_reg.stk, a);
						r_next.k = a;
						r_next.st = S_FETCH;
					end
				end
			end
			default: begin
				r_next = STATE_RST;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			r_reg <= STATE_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	assign prog_addr_out = r_reg.pc;
	assign mbf_addr_out  = r_reg.mbf_addr;
	assign res_out       = r_reg.res;
	assign busy_out      = r_reg.busy;
	assign done_out      = r_reg.done;

	property p_start;
		@(posedge clk_in) disable iff (rst_in)
		(r_reg.st == S_IDLE && start_in) |=>
			busy_out && prog_addr_out == $past(start_addr_in);
	endproperty
	a_start: assert property (p_start) else $error("start not taken");

	property p_handback;
		@(posedge clk_in) disable iff (rst_in)
		done_out |-> res_out.we && !busy_out ##1 !busy_out && !done_out;
	endproperty
	a_handback: assert property (p_handback) else $error("bad hand back");

	property p_min;
		@(posedge clk_in) disable iff (rst_in)
		(r_reg.st == S_DECODE && op_w == OP_MIN) |=>
			r_reg.k == ($past(top_w) < $past(nxt_w) ?
				$past(top_w) : $past(nxt_w));
	endproperty
	a_min: assert property (p_min) else $error("min wrong");

	property p_max;
		@(posedge clk_in) disable iff (rst_in)
		(r_reg.st == S_DECODE && op_w == OP_MAX) |=>
			r_reg.k == ($past(top_w) > $past(nxt_w) ?
				$past(top_w) : $past(nxt_w));
	endproperty
	a_max: assert property (p_max) else $error("max wrong");

	property p_save;
		@(posedge clk_in) disable iff (rst_in)
		(r_reg.st == S_DECODE && op_w == OP_SAVE) |=> r_reg.m == $past(r_reg.k);
	endproperty
	a_save: assert property (p_save) else $error("buffer not saved");

	property p_conseq;
		@(posedge clk_in) disable iff (rst_in)
		(r_reg.st == S_DECODE && op_w == OP_CONSEQ) |=>
			r_reg.den == $past(r_reg.den) + {8'h00, $past(r_reg.k)};
	endproperty
	a_conseq: assert property (p_conseq) else $error("weight sum wrong");

	property p_zero_den;
		@(posedge clk_in) disable iff (rst_in)
		(r_reg.st == S_DECODE && op_w == OP_OUT && r_reg.den == '0) |=>
			res_out.we && res_out.data == 8'h00;
	endproperty
	a_zero_den: assert property (p_zero_den) else $error("zero den");

	property p_clear;
		@(posedge clk_in) disable iff (rst_in)
		res_out.we |-> r_reg.num == '0 && r_reg.den == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("sums not cleared");

	property p_shape_addr;
		@(posedge clk_in) disable iff (rst_in)
		(r_reg.st == S_DECODE && op_w == OP_LOAD_ALPHA) |=>
			mbf_addr_out == 10'($past(mbf_idx_w)) * 10'h003 ##3
			r_reg.st == S_MBF && r_reg.cnt == MBF_LAST;
	endproperty
	a_shape_addr: assert property (p_shape_addr) else $error("shape fetch");

	property p_vertex;
		@(posedge clk_in) disable iff (rst_in)
		(r_reg.st == S_ALPHA && x_w == v_w) |=>
			r_reg.k == (cmp_w ? 4'h0 : ALPHA_MAX);
	endproperty
	a_vertex: assert property (p_vertex) else $error("vertex alpha");
endmodule // fde_engine

// ==== tb/fde_host_model.sv ====
`timescale 1ns/1ns
module fde_host_model (
	input  wire fde_pkg::fde_paddr_t prog_addr_in,
	input  wire fde_pkg::fde_maddr_t mbf_addr_in,
	input  wire logic                clk_in,
	output logic                     start_out,
	output fde_pkg::fde_paddr_t      start_addr_out,
	output logic [15:0]              instr_out,
	output logic [7:0]               mbf_data_out
);
	import fde_pkg::*;
	logic [15:0] prog_mem [0:255];
	logic [7:0]  shape_mem [0:1023];
	initial begin
		start_out = 1'b0;
		start_addr_out = '0;
		instr_out = 16'h0000;
		mbf_data_out = 8'h00;
		for (int i = 0; i < 256; i++) prog_mem[i] = 16'h0000;
		for (int i = 0; i < 1024; i++) shape_mem[i] = 8'h00;
	end
	// both memories answer one cycle after the address, like the real ROMs
	always @(posedge clk_in) begin
		instr_out <= prog_mem[prog_addr_in[7:0]];
		mbf_data_out <= shape_mem[mbf_addr_in];
	end
	// start stays up three edges: only the first lands while idle
	task automatic launch(input fde_paddr_t a);
		@(posedge clk_in);
		start_out <= 1'b1;
		start_addr_out <= a;
		repeat (3) @(posedge clk_in);
		start_out <= 1'b0;
	endtask
endmodule // fde_host_model

// ==== tb/fuzzy_decision_engine_tb.sv ====
`timescale 1ns/1ns
module fuzzy_decision_engine_tb;
	import fde_pkg::*;
	logic        clk_in;
	logic        rst_in;
	logic        start_in;
	fde_paddr_t  start_addr_in;
	fde_load_s   load_in;
	logic [15:0] instr_in;
	logic [7:0]  mbf_data_in;
	fde_paddr_t  prog_addr_out;
	fde_maddr_t  mbf_addr_out;
	fde_res_s    res_out;
	logic        busy_out;
	logic        done_out;
	int          mismatches;
	int          samples_checked;
	int          cycles;

	fde_engine i_dut (.clk_in(clk_in), .rst_in(rst_in), .start_in(start_in),
		.start_addr_in(start_addr_in), .load_in(load_in),
		.instr_in(instr_in), .mbf_data_in(mbf_data_in),
		.prog_addr_out(prog_addr_out), .mbf_addr_out(mbf_addr_out),
		.res_out(res_out), .busy_out(busy_out), .done_out(done_out));
	fde_host_model i_host (.prog_addr_in(prog_addr_out),
		.mbf_addr_in(mbf_addr_out), .clk_in(clk_in), .start_out(start_in),
		.start_addr_out(start_addr_in), .instr_out(instr_in),
		.mbf_data_out(mbf_data_in));

	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	task automatic test_done();
		if (mismatches == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			test_done();
		end
	end

	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [15:0] ins(input fde_op_e op, input logic last,
		input logic [2:0] sel, input logic [7:0] arg);
		return {op, last, sel, arg};
	endfunction

	task automatic set_in(input logic [2:0] sel, input logic [7:0] d);
		@(posedge clk_in);
		load_in <= '{we: 1'b1, sel: sel, data: d};
		@(posedge clk_in);
		load_in <= '0;
	endtask

	// waits for one result write and judges it
	task automatic run_out(input logic [6:0] a, input logic [7:0] d,
		input logic last);
		logic seen;
		seen = 1'b0;
		for (int i = 0; i < 400 && !seen; i++) begin
			@(posedge clk_in);
			#1;
			seen = (res_out.we === 1'b1);
		end
		check("result write", 16'h0001, 16'(seen));
		check("result addr", 16'(a), 16'(res_out.addr));
		check("result data", 16'(d), 16'(res_out.data));
		check("done", 16'(last), 16'(done_out));
		check("busy", 16'(!last), 16'(busy_out));
	endtask

	task automatic test_weighted();
		i_host.prog_mem[0] = ins(OP_LOAD_ALPHA, 1'b0, 3'h1, 8'h01);
		i_host.prog_mem[1] = ins(OP_LOAD_COMPL, 1'b0, 3'h1, 8'h01);
		i_host.prog_mem[2] = ins(OP_MAX, 1'b0, 3'h0, 8'h00);
		i_host.prog_mem[3] = ins(OP_CONSEQ, 1'b0, 3'h0, 8'hC8);
		i_host.prog_mem[4] = ins(OP_LOAD_ALPHA, 1'b0, 3'h0, 8'h01);
		i_host.prog_mem[5] = ins(OP_LOAD_ALPHA, 1'b0, 3'h2, 8'h01);
		i_host.prog_mem[6] = ins(OP_MIN, 1'b0, 3'h0, 8'h00);
		i_host.prog_mem[7] = ins(OP_CONSEQ, 1'b0, 3'h0, 8'h28);
		i_host.prog_mem[8] = ins(OP_OUT, 1'b1, 3'h0, 8'h05);
		i_host.launch(12'h000);
		// weights 8 and 7: (8*200 + 7*40) / 15
		run_out(7'h05, 8'h7D, 1'b1);
	endtask

	task automatic test_grouped();
		i_host.prog_mem[16] = ins(OP_LOAD_ALPHA, 1'b0, 3'h1, 8'h01);
		i_host.prog_mem[17] = ins(OP_LOAD_COMPL, 1'b0, 3'h1, 8'h01);
		i_host.prog_mem[18] = ins(OP_MAX, 1'b0, 3'h0, 8'h00);
		i_host.prog_mem[19] = ins(OP_SAVE, 1'b0, 3'h0, 8'h00);
		i_host.prog_mem[20] = ins(OP_LOAD_ALPHA, 1'b0, 3'h2, 8'h01);
		i_host.prog_mem[21] = ins(OP_LOAD_ALPHA, 1'b0, 3'h0, 8'h01);
		i_host.prog_mem[22] = ins(OP_MIN, 1'b0, 3'h0, 8'h00);
		i_host.prog_mem[23] = ins(OP_KEEP, 1'b0, 3'h0, 8'h00);
		i_host.prog_mem[24] = ins(OP_RESTORE, 1'b0, 3'h0, 8'h00);
		i_host.prog_mem[25] = ins(OP_MIN, 1'b0, 3'h0, 8'h00);
		i_host.prog_mem[26] = ins(OP_CONSEQ, 1'b0, 3'h0, 8'h32);
		i_host.prog_mem[27] = ins(OP_LOAD_ALPHA, 1'b0, 3'h0, 8'h01);
		i_host.prog_mem[28] = ins(OP_CONSEQ, 1'b0, 3'h0, 8'h00);
		i_host.prog_mem[29] = ins(OP_OUT, 1'b0, 3'h0, 8'h7F);
		i_host.prog_mem[30] = ins(OP_OUT, 1'b1, 3'h0, 8'h00);
		i_host.launch(12'h010);
		// grouped weight 7 against 15: 7*50 / 22
		run_out(7'h7F, 8'h0F, 1'b0);
		run_out(7'h00, 8'h00, 1'b1);
	endtask

	// four-antecedent rule, then one out: fetch, decode, divide steps
	task automatic test_rule_time();
		int n;
		i_host.prog_mem[32] = ins(OP_LOAD_ALPHA, 1'b0, 3'h1, 8'h01);
		i_host.prog_mem[33] = ins(OP_LOAD_ALPHA, 1'b0, 3'h2, 8'h01);
		i_host.prog_mem[34] = ins(OP_MIN, 1'b0, 3'h0, 8'h00);
		i_host.prog_mem[35] = ins(OP_KEEP, 1'b0, 3'h0, 8'h00);
		i_host.prog_mem[36] = ins(OP_LOAD_ALPHA, 1'b0, 3'h1, 8'h01);
		i_host.prog_mem[37] = ins(OP_MIN, 1'b0, 3'h0, 8'h00);
		i_host.prog_mem[38] = ins(OP_KEEP, 1'b0, 3'h0, 8'h00);
		i_host.prog_mem[39] = ins(OP_LOAD_ALPHA, 1'b0, 3'h2, 8'h01);
		i_host.prog_mem[40] = ins(OP_MIN, 1'b0, 3'h0, 8'h00);
		i_host.prog_mem[41] = ins(OP_CONSEQ, 1'b0, 3'h0, 8'h5A);
		i_host.prog_mem[42] = ins(OP_OUT, 1'b1, 3'h0, 8'h11);
		i_host.launch(12'h020);
		// launch returns two edges after the edge that raises busy
		n = 2;
		while (res_out.we !== 1'b1 && n < 400) begin
			@(posedge clk_in);
			#1;
			n++;
		end
		samples_checked++;
		if (n > RULE_CYCLES + 2 + DEFUZZ_STEPS) begin
			mismatches++;
			$display("[FAIL] rule cycles expected at most %0d seen %0d",
				RULE_CYCLES + 2 + DEFUZZ_STEPS, n);
		end
		check("timed result data", 16'h005A, 16'(res_out.data));
		check("timed result addr", 16'h0011, 16'(res_out.addr));
		check("timed done", 16'h0001, 16'(done_out));
	endtask

	initial begin
		rst_in = 1'b1;
		load_in = '0;
		mismatches = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (6) @(posedge clk_in);
		rst_in <= 1'b0;
		#1;
		check("idle busy", 16'h0000, 16'(busy_out));
		check("idle write", 16'h0000, 16'(res_out.we));
		// shape 1: left 10, vertex 100, right 10
		i_host.shape_mem[3] = 8'h0A;
		i_host.shape_mem[4] = 8'h64;
		i_host.shape_mem[5] = 8'h0A;
		set_in(3'h0, 8'h64);
		set_in(3'h1, 8'h5F);
		set_in(3'h2, 8'h69);
		test_weighted();
		test_grouped();
		test_rule_time();
		test_done();
	end
endmodule // fuzzy_decision_engine_tb
